/* File: rtl/tpsr_shift_register.sv */
// Two-phase dynamic recirculating shift register, modelled in synchronous logic
//
// Overview of operation
// - Serial bit rate is twice either phase frequency, within documented range.
// - A phase is active while low, inactive while high.
// - Master takes data on one phase, slave takes it on the other.
// - Data and select are sampled at the rising end of an active pulse.
// - Serial output updates at the falling start of an active pulse.
// - Two half-registers shift on opposite phases; a bit enters every pulse.
// - Bit entered on phase one shows at output from phase one to phase two.
// - In the recirculating variants, load control high recirculates the output; low enters external data.
// - Dual variant: two 1024-bit recirculating registers, one shared load control.
// - Single variant: one 2048-bit register with recirculation and load control.
`include "tpsr_regs.svh"
`default_nettype none

module tpsr_shift_register
  import tpsr_pkg::*;
#(
  parameter tpsr_variant_t VARIANT = TPSR_DUAL_RECIRC,
  parameter int REG_LEN = (VARIANT == TPSR_SINGLE_RECIRC) ? `TPSR_LEN_SINGLE : `TPSR_LEN_DUAL,
  parameter int FIFO_DEPTH = `TPSR_FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Two-phase clock from the controlling logic
  input wire tpsr_phases_t phases,
  // Control and serial data
  input wire logic loadRecirculateSelect,
  input wire tpsr_chan_in_t [`TPSR_MAX_CH-1:0] chanIn,
  output logic [`TPSR_MAX_CH-1:0] serialOut,
  // Status
  output logic phaseTimingFault,
  // Observation stream of output updates
  output logic obsValid,
  output logic [`TPSR_MAX_CH-1:0] obsData,
  input wire logic obsReady,
  output logic obsFillReady
);

  localparam int NUM_CH = (VARIANT == TPSR_SINGLE_RECIRC) ? 1 : 2;
  // Each register is two interleaved halves
  localparam int HALF = REG_LEN / 2;
  localparam logic [`TPSR_GAP_CNT_W-1:0] GAP_MIN = `TPSR_GAP_CNT_W'(`TPSR_PHASE_GAP_MIN_CYC);
  localparam logic [`TPSR_GAP_CNT_W-1:0] GAP_SAT = '1;

  // =====================================================
  // Parameter check
  if (REG_LEN < 4 || (REG_LEN % 2) != 0)
  begin : gBadLen
    $error("tpsr_shift_register needs an even register length of at least 4");
  end

  // Counter must reach the minimum gap before it saturates
  if (`TPSR_PHASE_GAP_MIN_CYC >= (1 << `TPSR_GAP_CNT_W) - 1)
  begin : gBadGap
    $error("tpsr_shift_register gap counter too narrow for the minimum gap");
  end

  // Plain flip-flops: a stopped phase clock loses nothing here, unlike the charge store
  typedef struct packed {
    logic phase1Prev;
    logic phase2Prev;
    logic [NUM_CH-1:0][HALF-1:0] half1;
    logic [NUM_CH-1:0][HALF-1:0] half2;
    logic [NUM_CH-1:0] master1;
    logic [NUM_CH-1:0] master2;
    logic [NUM_CH-1:0] outBit;
    logic [`TPSR_GAP_CNT_W-1:0] gapCnt;
    logic fault;
    logic obsPush;
  } tpsr_state_t;

  tpsr_state_t st_r;
  tpsr_state_t st_nxt;
  logic p1Fall;
  logic p1Rise;
  logic p2Fall;
  logic p2Rise;
  logic [NUM_CH-1:0] entered;
  logic [`TPSR_MAX_CH-1:0] outWide;
  logic fifoInReady;

  // =====================================================
  // Phase edges; low level means the phase is on
  assign p1Fall = st_r.phase1Prev && !phases.phase1N;
  assign p1Rise = !st_r.phase1Prev && phases.phase1N;
  assign p2Fall = st_r.phase2Prev && !phases.phase2N;
  assign p2Rise = !st_r.phase2Prev && phases.phase2N;

  // =====================================================
  // Bit to be entered per register
  always_comb
  begin
    entered = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (VARIANT == TPSR_DUAL_TWO_INPUT)
      begin
        entered[c] = chanIn[c].inputSourceSelect ? chanIn[c].secondSerialInput : chanIn[c].firstSerialInput;
      end
      else
      begin
        // Recirculation takes the bit now on the output
        entered[c] = loadRecirculateSelect ? st_r.outBit[c] : chanIn[c].firstSerialInput;
      end
    end
  end

  // =====================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.phase1Prev = phases.phase1N;
    st_nxt.phase2Prev = phases.phase2N;
    st_nxt.obsPush = p1Fall || p2Fall;
    for (int c = 0; c < NUM_CH; c++)
    begin
      // Masters capture at the end of their own pulse
      if (p1Rise)
      begin
        st_nxt.master1[c] = entered[c];
      end
      if (p2Rise)
      begin
        st_nxt.master2[c] = entered[c];
      end
      // Slaves take the master bit when the opposite phase starts
      if (p2Fall)
      begin
        st_nxt.half1[c] = {st_r.half1[c][HALF-2:0], st_r.master1[c]};
      end
      if (p1Fall)
      begin
        st_nxt.half2[c] = {st_r.half2[c][HALF-2:0], st_r.master2[c]};
      end
      // One bit per pulse of either phase, so bit rate is twice phase rate
      // Output follows the start of each pulse
      if (p1Fall)
      begin
        st_nxt.outBit[c] = st_r.half1[c][HALF-1];
      end
      else if (p2Fall)
      begin
        st_nxt.outBit[c] = st_r.half2[c][HALF-1];
      end
    end
    // Gap counter runs only while both phases are off
    if (!phases.phase1N || !phases.phase2N)
    begin
      st_nxt.gapCnt = '0;
    end
    else if (st_r.gapCnt != GAP_SAT)
    begin
      st_nxt.gapCnt = `TPSR_GAP_CNT_W'(st_r.gapCnt + 1'b1);
    end
    // Sticky until reset; the device cannot trust its charge after a violation
    if (!phases.phase1N && !phases.phase2N)
    begin
      st_nxt.fault = 1'b1;
    end
    if ((p1Fall || p2Fall) && st_r.gapCnt < GAP_MIN)
    begin
      st_nxt.fault = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
      st_r.phase1Prev <= 1'b1;
      st_r.phase2Prev <= 1'b1;
      st_r.gapCnt <= GAP_SAT;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // =====================================================
  // Outputs
  always_comb
  begin
    outWide = '0;
    outWide[NUM_CH-1:0] = st_r.outBit;
  end

  assign serialOut = outWide;
  assign phaseTimingFault = st_r.fault;
  assign obsFillReady = fifoInReady;

  // Drops samples when full rather than stalling; the register itself must never stop
  tpsr_fifo #(
    .WIDTH(`TPSR_MAX_CH),
    .DEPTH(FIFO_DEPTH)
  ) uObsFifo (
    .clk(clk),
    .resetn(resetn),
    .inValid(st_r.obsPush),
    .inData(outWide),
    .inReady(fifoInReady),
    .outValid(obsValid),
    .outData(obsData),
    .outReady(obsReady)
  );

endmodule

`default_nettype wire

/* File: rtl/tpsr_regs.svh */
// Constants of the two-phase recirculating shift register
`ifndef TPSR_REGS_SVH
`define TPSR_REGS_SVH

// =====================================================
// Storage sizes
`define TPSR_MAX_CH 2
`define TPSR_LEN_DUAL 1024
`define TPSR_LEN_SINGLE 2048
`define TPSR_FIFO_DEPTH 8

// =====================================================
// Timing
`define TPSR_CLK_PERIOD_NS 10
`define TPSR_PHASE_FREQ_MAX_KHZ 3000
`define TPSR_PHASE_FREQ_MIN_KHZ 10
`define TPSR_PHASE_GAP_MIN_NS 10
`define TPSR_PHASE_GAP_MIN_CYC ((`TPSR_PHASE_GAP_MIN_NS + `TPSR_CLK_PERIOD_NS - 1) / `TPSR_CLK_PERIOD_NS)
`define TPSR_GAP_CNT_W 4

`endif

/* File: rtl/tpsr_pkg.sv */
// Types of the two-phase recirculating shift register
`default_nettype none

package tpsr_pkg;

  // =====================================================
  // Device variants
  typedef enum logic [1:0] {
    TPSR_DUAL_RECIRC,
    TPSR_DUAL_TWO_INPUT,
    TPSR_SINGLE_RECIRC
  } tpsr_variant_t;

  // =====================================================
  // Carriers
  typedef struct packed {
    logic phase1N;
    logic phase2N;
  } tpsr_phases_t;

  typedef struct packed {
    logic firstSerialInput;
    logic secondSerialInput;
    logic inputSourceSelect;
  } tpsr_chan_in_t;

endpackage

`default_nettype wire

/* File: rtl/tpsr_fifo.sv */
// Small synchronous FIFO for the output observation stream
`default_nettype none

module tpsr_fifo
  import tpsr_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // =====================================================
  // Parameter check
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
  begin : gBadParams
    $error("tpsr_fifo needs a power-of-two depth of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } tpsr_fifo_state_t;

  tpsr_fifo_state_t st_r;
  tpsr_fifo_state_t st_nxt;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty without a counter
  assign empty = (st_r.wrPtr == st_r.rdPtr);
  assign full = (st_r.wrPtr[AW] != st_r.rdPtr[AW]) && (st_r.wrPtr[AW-1:0] == st_r.rdPtr[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = st_r.mem[st_r.rdPtr[AW-1:0]];

  // =====================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    if (inValid && !full)
    begin
      st_nxt.mem[st_r.wrPtr[AW-1:0]] = inData;
      st_nxt.wrPtr = (AW+1)'(st_r.wrPtr + 1'b1);
    end
    if (outReady && !empty)
    begin
      st_nxt.rdPtr = (AW+1)'(st_r.rdPtr + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

`default_nettype wire

/* File: sim/tpsr_shift_register_props.sv */
// Port checker of the two-phase shift register
`include "tpsr_regs.svh"
`default_nettype none

module tpsr_sr_chk
  import tpsr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Watched ports
  input wire tpsr_phases_t phases,
  input wire logic loadRecirculateSelect,
  input wire tpsr_chan_in_t [`TPSR_MAX_CH-1:0] chanIn,
  input wire logic [`TPSR_MAX_CH-1:0] serialOut,
  input wire logic phaseTimingFault,
  input wire logic obsValid,
  input wire logic [`TPSR_MAX_CH-1:0] obsData,
  input wire logic obsReady,
  input wire logic obsFillReady
);
  tpsr_phases_t phPrev_r;
  logic fallAny;
  logic badPhases;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      phPrev_r <= 2'h3;
    else
      phPrev_r <= phases;
  end

  assign fallAny = (phPrev_r.phase1N & ~phases.phase1N) | (phPrev_r.phase2N & ~phases.phase2N);
  // Overlap, or one phase ending as the other starts with no gap
  assign badPhases = (~phases.phase1N & ~phases.phase2N) | (~phPrev_r.phase1N & ~phases.phase2N) |
    (~phPrev_r.phase2N & ~phases.phase1N);

  // =====================================================
  // Properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_bad;
    badPhases;
  endsequence
  sequence s_faultSoon;
    ##[1:2] phaseTimingFault;
  endsequence

  property p_outUpd; !$stable(serialOut) |-> $past(fallAny); endproperty
  a_outUpd: assert property (p_outUpd) else $error("output moved without a phase fall");
  property p_badFault; s_bad |-> s_faultSoon; endproperty
  a_badFault: assert property (p_badFault) else $error("bad phasing not flagged");
  property p_sticky; phaseTimingFault |=> phaseTimingFault; endproperty
  a_sticky: assert property (p_sticky) else $error("fault flag dropped");
  property p_cause; $rose(phaseTimingFault) |-> $past(badPhases) || $past(badPhases, 2); endproperty
  a_cause: assert property (p_cause) else $error("fault without cause");
  property p_push; fallAny && obsFillReady |-> ##[1:3] obsValid; endproperty
  a_push: assert property (p_push) else $error("snapshot not queued");
  property p_head; $rose(obsValid) |-> obsData == serialOut; endproperty
  a_head: assert property (p_head) else $error("snapshot differs from output");
  property p_full; !obsFillReady |-> obsValid; endproperty
  a_full: assert property (p_full) else $error("full while empty");
  property p_empty; !obsValid |-> obsFillReady; endproperty
  a_empty: assert property (p_empty) else $error("not ready while empty");
endmodule

bind tpsr_shift_register tpsr_sr_chk chk (.clk(clk), .resetn(resetn), .phases(phases),
  .loadRecirculateSelect(loadRecirculateSelect), .chanIn(chanIn), .serialOut(serialOut),
  .phaseTimingFault(phaseTimingFault), .obsValid(obsValid), .obsData(obsData), .obsReady(obsReady),
  .obsFillReady(obsFillReady));

`default_nettype wire

/* File: sim/tpsr_phase_drv.sv */
// Model of the controlling logic: two-phase clock, data and load control
`default_nettype none

module tpsr_phase_drv
  import tpsr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Towards the register
  output var tpsr_phases_t phases,
  output var logic loadRecirculateSelect,
  output var tpsr_chan_in_t [1:0] chanIn
);
  timeunit 1ns;
  timeprecision 100ps;
  // 16 cycles low plus the gap keeps width over its floor and phase rate under its ceiling
  localparam int PW_MIN_CYC = 16;

  initial
  begin
    phases = 2'h3; // Both inactive high
    loadRecirculateSelect = 1'h0;
    chanIn = 6'h00;
  end

  // One active pulse, PW_MIN_CYC + w cycles low; both forces the overlap fault
  task automatic pulse(input logic ph2, input logic both, input int w, input logic lc, input tpsr_chan_in_t [1:0] ci);
    @(negedge clk);
    loadRecirculateSelect = lc;
    chanIn = ci;
    phases = both ? 2'h0 : (ph2 ? 2'h2 : 2'h1); // Active low
    repeat (PW_MIN_CYC + w) @(negedge clk); // Width kept in range
    phases = 2'h3; // Inputs held over the rising end
    @(negedge clk); // Gap before the other phase
    loadRecirculateSelect = ~lc; // Hold over: stale levels must not be trusted
    chanIn = ~ci;
  endtask
endmodule

`default_nettype wire

/* File: sim/tpsr_shift_register_tb.sv */
// Self-checking bench of the shift register with its partner model
`default_nettype none

module tpsr_shift_register_tb import tpsr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LEN = 4;
  typedef struct packed {logic lc; tpsr_chan_in_t [1:0] ci; logic [1:0] entB;} tpsr_row_t;
  tpsr_row_t rows [12] = '{9'h08A, 9'h076, 9'h03D, 9'h0C2, 9'h151, 9'h1AD, 9'h1E6, 9'h119, 9'h151, 9'h1AD,
    9'h1E6, 9'h119};
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic obsReady = 1'h0;
  tpsr_phases_t phases;
  tpsr_chan_in_t [1:0] chanIn;
  logic lc, fault, obsValid, fillReady;
  logic [1:0] soA, soB, soC, obsData;
  logic [1:0] histA [16] = '{default: 2'h0};
  logic [1:0] histB [16] = '{default: 2'h0};
  int n_fail = 0;
  int total_checks = 0;

  always #5 clk = ~clk;

  tpsr_phase_drv drv (.clk(clk), .phases(phases), .loadRecirculateSelect(lc), .chanIn(chanIn));
  tpsr_shift_register #(.VARIANT(TPSR_DUAL_RECIRC), .REG_LEN(LEN)) uut (.clk(clk), .resetn(resetn),
    .phases(phases), .loadRecirculateSelect(lc), .chanIn(chanIn), .serialOut(soA), .phaseTimingFault(fault),
    .obsValid(obsValid), .obsData(obsData), .obsReady(obsReady), .obsFillReady(fillReady));
  tpsr_shift_register #(.VARIANT(TPSR_DUAL_TWO_INPUT), .REG_LEN(LEN)) uut2 (.clk(clk), .resetn(resetn),
    .phases(phases), .loadRecirculateSelect(lc), .chanIn(chanIn), .serialOut(soB), .phaseTimingFault(),
    .obsValid(), .obsData(), .obsReady(obsReady), .obsFillReady());
  tpsr_shift_register #(.VARIANT(TPSR_SINGLE_RECIRC), .REG_LEN(LEN)) uut3 (.clk(clk), .resetn(resetn),
    .phases(phases), .loadRecirculateSelect(lc), .chanIn(chanIn), .serialOut(soC), .phaseTimingFault(),
    .obsValid(), .obsData(), .obsReady(obsReady), .obsFillReady());

  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #20000;
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    repeat (6) @(negedge clk);
    check(soA, 2'h0); // Cleared storage output
    check({obsValid, fillReady}, 2'h1); // Empty buffer
    resetn = 1'h1;
    $display("test reset done");
    // One bit per pulse, back after LEN pulses
    for (int i = 0; i < 12; i++)
    begin
      drv.pulse(i[0], 1'h0, 2 + i % 3, rows[i].lc, rows[i].ci);
      check(soA, histA[i]);
      check(soB, histB[i]);
      check(soC, {1'h0, histA[i][0]});
      histA[i + LEN] = rows[i].lc ? histA[i] : {rows[i].ci[1].firstSerialInput, rows[i].ci[0].firstSerialInput};
      histB[i + LEN] = rows[i].entB;
      repeat (i % 4) @(negedge clk);
    end
    check({obsValid, fillReady}, 2'h2); // Full after stalled drain
    $display("test rows done");
    for (int k = 0; k < 8; k++)
    begin
      check(obsData, histA[k]); // Snapshots in update order
      obsReady = 1'h1;
      @(negedge clk);
    end
    obsReady = 1'h0;
    check({obsValid, fillReady}, 2'h1); // Drained
    check({1'h0, fault}, 2'h0); // Clean phasing
    $display("test fifo done");
    drv.pulse(1'h0, 1'h1, 2, 1'h0, 6'h00);
    check({1'h0, fault}, 2'h1); // Overlap flagged
    resetn = 1'h0;
    @(negedge clk);
    check({fault, soA[0]}, 2'h0); // Cleared by reset
    resetn = 1'h1;
    $display("test fault done");
    report_and_stop();
  end
endmodule

`default_nettype wire
